// [rtl/mpc_port_ctrl.sv]
// mpc_port_ctrl: general-purpose port pin logic of one microcontroller.
// assumes control fields come from same-clock register logic; pins are asynchronous.
// Notes on behaviour
// - Every bit of every two-way port has its own software direction bit.
// - A pull-up acts only when requested and the bit is an input.
// - Port 1 used as analog inputs must be inputs, and its pull-ups are forced off.
// - Ports 8 and 9 switch pin pairs between port and segment drive in 2-bit groups.
// - Falling edges on the three upper bits of port 11 are recorded for software.
`timescale 1ns/1ns
module mpc_port_ctrl import mpc_pkg::*; #(
  parameter int unsigned NP = NUM_PORTS
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    srst_i,
  // software write strobes and data, one port per index
  input  wire logic [NP-1:0]           dir_we_i,
  input  wire logic [NP-1:0]           pull_we_i,
  input  wire logic [NP-1:0]           out_we_i,
  input  wire logic [PORT_W-1:0]       wdata_i,
  input  wire logic                    lcd_display_ctrl_we_i,
  input  wire logic [SEG_GROUPS-1:0]   lcd_display_ctrl_i,
  input  wire logic                    analog_mode_i,
  input  wire logic [7:0]              processor_clock_ctrl_i,
  input  wire logic                    edge_cfg_we_i,
  input  wire logic [2*NUM_EXT_IRQ-1:0] edge_cfg_i,
  input  wire logic                    edge_flag_clr_i,
  input  wire logic [EDGE_BITS-1:0]    edge_flag_clr_mask_i,
  // segment drive from the lcd block
  input  wire logic [2*PORT_W-1:0]     shared_segment_outputs_i,
  // pins
  input  wire logic [NP*PORT_W-1:0]    pin_in_i,
  input  wire logic                    subclock_crystal_in_i,
  output logic      [NP*PORT_W-1:0]    pin_out_o,
  output logic      [NP*PORT_W-1:0]    pin_oe_o,
  output logic      [NP*PORT_W-1:0]    pull_en_o,
  output logic      [NP*PORT_W-1:0]    port_rd_o,
  output logic                         subclock_shared_input_o,
  output logic                         subclock_feedback_off_o,
  output logic      [SEG_GROUPS-1:0]   lcd_display_ctrl_o,
  output logic      [NUM_EXT_IRQ-1:0]  ext_irq_req_o,
  output logic      [EDGE_BITS-1:0]    port11_edge_bits_o
);
  // port index map: 0 port0, 1 port1, 2 port2, 3 port3, 4 port7, 5 port8, 6 port9, 7 port10, 8 port11
  localparam int unsigned IDX_P0  = 0;
  localparam int unsigned IDX_P1  = 1;
  localparam int unsigned IDX_P8  = 5;
  localparam int unsigned IDX_P9  = 6;
  localparam int unsigned IDX_P11 = 8;
  localparam logic [PORT_W-1:0] P0_IN_ONLY = 8'h81;  // port 0 bits 0 and 7 have no output stage

  logic [PORT_W-1:0] dir  [NP];
  logic [PORT_W-1:0] pull [NP];
  logic [PORT_W-1:0] outv [NP];
  logic [SEG_GROUPS-1:0]    seg_sel;
  logic [2*NUM_EXT_IRQ-1:0] edge_cfg;
  logic [EDGE_BITS-1:0]     p11_flag;
  logic [NUM_EXT_IRQ-1:0]   irq_req;
  logic [NP*PORT_W-1:0]     lvl, rise, fall;
  logic                     xt_meta, xt_sync;
  logic [PORT_W-1:0]        dir_eff [NP];

  function automatic logic edge_hit(input logic [1:0] cfg, input logic r, input logic f);
    case (cfg)
      EDGE_RISE: edge_hit = r;
      EDGE_FALL: edge_hit = f;
      EDGE_BOTH: edge_hit = r | f;
      default:   edge_hit = 1'b0;
    endcase
  endfunction

  // flat pin index of bit b of port index p
  function automatic int pin_idx(input int p, input int b);
    pin_idx = p * PORT_W + b;
  endfunction

  mpc_sync_edge #(.W(NP*PORT_W)) u_sync (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pin_i     (pin_in_i),
    .level_o   (lvl),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  // per-bit direction, 1 = input
  always_ff @(posedge clk_sys_i) begin
    for (int p = 0; p < NP; p++) begin
      if (srst_i) begin
        dir[p] <= DIR_RST;
      end else if (dir_we_i[p]) begin
        dir[p] <= wdata_i;
      end
    end
  end

  // pull-up requests
  always_ff @(posedge clk_sys_i) begin
    for (int p = 0; p < NP; p++) begin
      if (srst_i) begin
        pull[p] <= PULL_RST;
      end else if (pull_we_i[p]) begin
        pull[p] <= wdata_i;
      end
    end
  end

  // output latches
  always_ff @(posedge clk_sys_i) begin
    for (int p = 0; p < NP; p++) begin
      if (srst_i) begin
        outv[p] <= OUT_RST;
      end else if (out_we_i[p]) begin
        outv[p] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      seg_sel <= SEG_RST;
    end else if (lcd_display_ctrl_we_i) begin
      seg_sel <= lcd_display_ctrl_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      edge_cfg <= '0;
    end else if (edge_cfg_we_i) begin
      edge_cfg <= edge_cfg_i;
    end
  end

  // input-only bits of port 0 always behave as inputs
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      dir_eff[p] = dir[p];
    end
    dir_eff[IDX_P0] = dir[IDX_P0] | P0_IN_ONLY;
  end

  // output enables: output bits and selected segment pairs
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      for (int b = 0; b < PORT_W; b++) begin
        pin_oe_o[pin_idx(p, b)] = ~dir_eff[p][b];
      end
    end
    for (int g = 0; g < SEG_GROUPS; g++) begin
      if (seg_sel[g]) begin
        pin_oe_o[pin_idx(IDX_P8, 2*g) +: 2] = 2'h3;
      end
    end
  end

  // output levels: latch, or segment data on a selected pair
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pin_out_o[pin_idx(p, 0) +: PORT_W] = outv[p];
    end
    for (int g = 0; g < SEG_GROUPS; g++) begin
      if (seg_sel[g]) begin
        pin_out_o[pin_idx(IDX_P8, 2*g) +: 2] = shared_segment_outputs_i[2*g +: 2];
      end
    end
  end

  // pull-ups: requested input bits only
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pull_en_o[pin_idx(p, 0) +: PORT_W] = pull[p] & dir_eff[p];
    end
    // input-only bits of port 0 carry no pull-up
    pull_en_o[pin_idx(IDX_P0, 0) +: PORT_W] = pull[IDX_P0] & dir_eff[IDX_P0] & ~P0_IN_ONLY;
    if (analog_mode_i) begin
      pull_en_o[pin_idx(IDX_P1, 0) +: PORT_W] = '0;
    end
    for (int g = 0; g < SEG_GROUPS; g++) begin
      if (seg_sel[g]) begin
        pull_en_o[pin_idx(IDX_P8, 2*g) +: 2] = 2'h0;
      end
    end
  end

  // read-back: pin level for inputs, latch for outputs
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      port_rd_o[pin_idx(p, 0) +: PORT_W] = (dir_eff[p] & lvl[pin_idx(p, 0) +: PORT_W])
                                         | (~dir_eff[p] & outv[p]);
    end
    port_rd_o[pin_idx(IDX_P0, 7)] = xt_sync;                    // subclock pin doubles as port 0 bit 7
  end

  // subclock pin sampled on its own synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      xt_meta <= 1'b0;
      xt_sync <= 1'b0;
    end else begin
      xt_meta <= subclock_crystal_in_i;
      xt_sync <= xt_meta;
    end
  end

  assign subclock_feedback_off_o = processor_clock_ctrl_i[FBOFF_BIT];
  assign subclock_shared_input_o = xt_sync;
  assign lcd_display_ctrl_o      = seg_sel;

  // sticky falling-edge flags, set wins over clear
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < EDGE_BITS; i++) begin
      if (srst_i)
        p11_flag[i] <= 1'b0;
      else if (fall[IDX_P11*PORT_W+EDGE_LSB+i])
        p11_flag[i] <= 1'b1;
      else if (edge_flag_clr_i && edge_flag_clr_mask_i[i])
        p11_flag[i] <= 1'b0;
    end
  end
  assign port11_edge_bits_o = p11_flag;

  // external interrupt requests on port 0 bits 0..5
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < NUM_EXT_IRQ; i++) begin
      if (srst_i)
        irq_req[i] <= 1'b0;
      else
        irq_req[i] <= edge_hit(edge_cfg[2*i +: 2], rise[IDX_P0*PORT_W+i],
                               fall[IDX_P0*PORT_W+i]);
    end
  end
  assign ext_irq_req_o = irq_req;
endmodule

// [rtl/mpc_pkg.sv]
// mpc_pkg: constants for the port pin control block.
// assumes a single system clock with synchronous reset.
package mpc_pkg;
  localparam int unsigned NUM_PORTS     = 9;   // ports 1,2,3,7,8,9,10,11 and port 0 bits
  localparam int unsigned PORT_W        = 8;
  localparam int unsigned SEG_GROUPS    = 8;   // 2-bit groups over ports 8 and 9
  localparam int unsigned NUM_EXT_IRQ   = 6;
  localparam int unsigned EDGE_BITS     = 3;   // upper bits of port 11
  localparam int unsigned EDGE_LSB      = 5;
  localparam int unsigned FBOFF_BIT     = 6;   // feedback-off bit in processor clock control
  localparam logic [7:0]  DIR_RST       = 8'hFF;  // 1 = input
  localparam logic [7:0]  PULL_RST      = 8'h00;
  localparam logic [7:0]  OUT_RST       = 8'h00;
  localparam logic [SEG_GROUPS-1:0] SEG_RST = 8'h00;
  localparam logic [1:0]  EDGE_NONE     = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  typedef enum logic [1:0] {MPC_ST_IDLE, MPC_ST_RUN} mpc_state_t;
endpackage

// [rtl/mpc_sync_edge.sv]
// mpc_sync_edge: two-flop synchroniser with rising/falling edge pulses.
// assumes asynchronous pin inputs and one system clock.
`timescale 1ns/1ns
module mpc_sync_edge import mpc_pkg::*; #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;
  logic [2:0]   fill;  // edges held off until prev holds a real pin sample

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      prev <= sync;
    end
  end

  // no false edge while the pipeline still holds reset values
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fill <= 3'h0;
    end else begin
      fill <= {fill[1:0], 1'h1};
    end
  end

  assign level_o = sync;
  assign rise_o  = fill[2] ? (sync & ~prev) : '0;
  assign fall_o  = fill[2] ? (~sync & prev) : '0;
endmodule

// [verification/mpc_port_ctrl_asserts.sv]
// checker for the port pin control block ports
// assumes one clock and sync reset, bound to every block instance
`timescale 1ns/1ns
module mpc_port_ctrl_asserts import mpc_pkg::*; #(
  parameter int unsigned NP = NUM_PORTS
) (
  input wire logic                  clk_sys_i,
  input wire logic                  srst_i,
  input wire logic [NP-1:0]         dir_we_i,
  input wire logic [PORT_W-1:0]     wdata_i,
  input wire logic                  lcd_display_ctrl_we_i,
  input wire logic [SEG_GROUPS-1:0] lcd_display_ctrl_i,
  input wire logic                  analog_mode_i,
  input wire logic [7:0]            processor_clock_ctrl_i,
  input wire logic [2*PORT_W-1:0]   shared_segment_outputs_i,
  input wire logic [NP*PORT_W-1:0]  pin_in_i,
  input wire logic                  edge_flag_clr_i,
  input wire logic [NP*PORT_W-1:0]  pin_out_o,
  input wire logic [NP*PORT_W-1:0]  pin_oe_o,
  input wire logic [NP*PORT_W-1:0]  pull_en_o,
  input wire logic                  subclock_feedback_off_o,
  input wire logic [SEG_GROUPS-1:0] lcd_display_ctrl_o,
  input wire logic [NUM_EXT_IRQ-1:0] ext_irq_req_o,
  input wire logic [EDGE_BITS-1:0]  port11_edge_bits_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence pin0_moved;
    $past(pin_in_i[0], 2) != $past(pin_in_i[0], 3) || $past(pin_in_i[0], 3) != $past(pin_in_i[0], 4)
      || $past(pin_in_i[0], 4) != $past(pin_in_i[0], 5);
  endsequence
  sequence p115_fell;
    $past(pin_in_i[69], 3) && !$past(pin_in_i[69], 2) || $past(pin_in_i[69], 4) && !$past(pin_in_i[69], 3)
      || $past(pin_in_i[69], 5) && !$past(pin_in_i[69], 4);
  endsequence
  dir_write_a: assert property (dir_we_i[3] |=> pin_oe_o[31:24] == ~$past(wdata_i))
    else $error("port direction write not applied");
  pull_input_a: assert property ((pull_en_o & pin_oe_o) == '0)
    else $error("pull-up on a driven bit");
  analog_pull_a: assert property (analog_mode_i |-> pull_en_o[15:8] == 8'h00)
    else $error("pull-up on analog input");
  seg_write_a: assert property (lcd_display_ctrl_we_i |=> lcd_display_ctrl_o == $past(lcd_display_ctrl_i))
    else $error("segment select not stored");
  seg_drive_a: assert property (lcd_display_ctrl_o[0] |-> pin_oe_o[41:40] == 2'h3
    && pin_out_o[41:40] == shared_segment_outputs_i[1:0]) else $error("segment pair not driven");
  flag_cause_a: assert property ($rose(port11_edge_bits_o[0]) |-> p115_fell)
    else $error("edge flag without falling edge");
  flag_hold_a: assert property (port11_edge_bits_o[0] && !edge_flag_clr_i |=> port11_edge_bits_o[0])
    else $error("edge flag lost");
  irq_cause_a: assert property (ext_irq_req_o[0] |-> pin0_moved)
    else $error("interrupt without pin edge");
  fboff_pass_a: assert property (subclock_feedback_off_o == processor_clock_ctrl_i[FBOFF_BIT])
    else $error("feedback-off bit not passed");
  reset_idle_a: assert property (@(posedge clk_sys_i) disable iff (1'b0) srst_i |=> pin_oe_o == '0
    && pull_en_o == '0 && lcd_display_ctrl_o == '0 && port11_edge_bits_o == '0) else $error("not idle after reset");
endmodule
bind mpc_port_ctrl mpc_port_ctrl_asserts #(.NP(NP)) chk_i (.clk_sys_i, .srst_i, .dir_we_i, .wdata_i,
  .lcd_display_ctrl_we_i, .lcd_display_ctrl_i, .analog_mode_i, .processor_clock_ctrl_i, .shared_segment_outputs_i,
  .pin_in_i, .edge_flag_clr_i, .pin_out_o, .pin_oe_o, .pull_en_o, .subclock_feedback_off_o, .lcd_display_ctrl_o,
  .ext_irq_req_o, .port11_edge_bits_o);

// [verification/mpc_port_ctrl_tb.sv]
// self-checking bench for the port pin control block
// assumes inputs driven at falling edge, outputs settled one cycle after writes
`timescale 1ns/1ns
module mpc_port_ctrl_tb import mpc_pkg::*;;
  logic clk_sys_i = 0, srst_i = 1, lcd_display_ctrl_we_i = 0, analog_mode_i = 0, edge_cfg_we_i = 0;
  logic edge_flag_clr_i = 0, subclock_crystal_in_i = 1, subclock_shared_input_o, subclock_feedback_off_o;
  logic [8:0] dir_we_i = 0, pull_we_i = 0, out_we_i = 0;
  logic [7:0] wdata_i = 0, lcd_display_ctrl_i = 0, processor_clock_ctrl_i = 0, lcd_display_ctrl_o, d;
  logic [11:0] edge_cfg_i = 0;
  logic [2:0] edge_flag_clr_mask_i = 0, port11_edge_bits_o;
  logic [15:0] shared_segment_outputs_i = 0;
  logic [71:0] pin_in_i = '1, pin_out_o, pin_oe_o, pull_en_o, port_rd_o;
  logic [5:0] ext_irq_req_o;
  logic [7:0] m_dir[9], m_pull[9], m_out[9], m_seg;
  int err_count = 0, cmp_count = 0, seed = 50, p, cnt, op, n_edges;
  always #20 clk_sys_i = ~clk_sys_i;
  mpc_port_ctrl mpc_port_ctrl_i (.clk_sys_i, .srst_i, .dir_we_i, .pull_we_i, .out_we_i, .wdata_i,
    .lcd_display_ctrl_we_i, .lcd_display_ctrl_i, .analog_mode_i, .processor_clock_ctrl_i, .edge_cfg_we_i,
    .edge_cfg_i, .edge_flag_clr_i, .edge_flag_clr_mask_i, .shared_segment_outputs_i, .pin_in_i,
    .subclock_crystal_in_i, .pin_out_o, .pin_oe_o, .pull_en_o, .port_rd_o, .subclock_shared_input_o,
    .subclock_feedback_off_o, .lcd_display_ctrl_o, .ext_irq_req_o, .port11_edge_bits_o);
  task automatic chk(input string n, input logic [71:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic check_all(input bit rd_on);
    logic [71:0] oe, pu, po, rd;
    for (int k = 0; k < 9; k++) begin
      oe[k*8+:8] = ~m_dir[k];
      pu[k*8+:8] = m_pull[k] & m_dir[k];
      po[k*8+:8] = m_out[k];
    end
    for (int g = 0; g < 8; g++) if (m_seg[g]) begin
      oe[40+2*g+:2] = 2'h3;
      pu[40+2*g+:2] = 2'h0;
      po[40+2*g+:2] = shared_segment_outputs_i[2*g+:2];
    end
    if (analog_mode_i) pu[15:8] = 8'h00;
    pu[0] = 1'b0;
    pu[7] = 1'b0;
    chk("oe", pin_oe_o, oe);
    chk("pull", pull_en_o, pu);
    chk("out", pin_out_o, po);
    chk("seg", lcd_display_ctrl_o, m_seg);
    chk("fboff", subclock_feedback_off_o, processor_clock_ctrl_i[6]);
    if (rd_on) begin
      for (int k = 0; k < 9; k++) rd[k*8+:8] = (m_dir[k] & pin_in_i[k*8+:8]) | (~m_dir[k] & m_out[k]);
      rd[7] = subclock_crystal_in_i;
      chk("rd", port_rd_o, rd);
      chk("xt", subclock_shared_input_o, subclock_crystal_in_i);
    end
  endtask
  task automatic run(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      cnt += $countones(ext_irq_req_o);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial begin
    foreach (m_dir[k]) {m_dir[k], m_pull[k], m_out[k]} = {DIR_RST, PULL_RST, OUT_RST};
    m_seg = SEG_RST;
    repeat (3) @(negedge clk_sys_i);
    srst_i = 0;
    check_all(0);
    pin_in_i[31:0] = $random(seed);
    pin_in_i[63:32] = $random(seed);
    pin_in_i[71:64] = 8'($random(seed));
    subclock_crystal_in_i = 1'($random(seed));
    run(3);
    repeat (60) begin
      p = {$random(seed)} % 9;
      d = $random(seed);
      op = {$random(seed)} % 4;
      wdata_i = d;
      shared_segment_outputs_i = $random(seed);
      processor_clock_ctrl_i = $random(seed);
      dir_we_i = 9'(op == 0) << p;
      pull_we_i = 9'(op == 1) << p;
      out_we_i = 9'(op == 2) << p;
      lcd_display_ctrl_we_i = (op == 3);
      case (op)
        0: m_dir[p] = (p == 0) ? d | 8'h81 : d;
        1: m_pull[p] = d;
        2: m_out[p] = d;
        default: begin lcd_display_ctrl_i = d; m_seg = d; end
      endcase
      analog_mode_i = (m_dir[1] == 8'hFF) & $random(seed);
      @(negedge clk_sys_i);
      check_all(1);
    end
    {dir_we_i, pull_we_i, out_we_i, lcd_display_ctrl_we_i} = '0;
    srst_i = 1;
    pin_in_i = '1;
    repeat (2) @(negedge clk_sys_i);
    srst_i = 0;
    foreach (m_dir[k]) {m_dir[k], m_pull[k], m_out[k]} = {DIR_RST, PULL_RST, OUT_RST};
    m_seg = SEG_RST;
    check_all(0);
    run(4);
    foreach (m_out[k]) begin
      edge_cfg_we_i = 1;
      edge_cfg_i = {6{k[1:0]}};
      @(negedge clk_sys_i);
      edge_cfg_we_i = 0;
      cnt = 0;
      {pin_in_i[71:69], pin_in_i[5:0]} = '0;
      run(8);
      {pin_in_i[71:69], pin_in_i[5:0]} = '1;
      run(8);
      n_edges = (k[1:0] == EDGE_FALL || k[1:0] == EDGE_BOTH) + (k[1:0] == EDGE_RISE || k[1:0] == EDGE_BOTH);
      chk("irq", cnt, NUM_EXT_IRQ * n_edges);
      chk("flag", port11_edge_bits_o, 3'h7);
      {edge_flag_clr_i, edge_flag_clr_mask_i} = 4'hF;
      @(negedge clk_sys_i);
      edge_flag_clr_i = 0;
      run(1);
      chk("flag clr", port11_edge_bits_o, 3'h0);
    end
    give_verdict();
  end
endmodule
